// ---- design/wprx_pkg.sv ----
// Constants, register map and types of the wireless power receiver control
package wprx_pkg;
    // ========================================================
    // Timing
    localparam int CLK_HZ = 25_000_000;
    localparam int BIT_RATE_BPS = 2000;
    localparam int BIT_CYC = CLK_HZ / BIT_RATE_BPS;
    localparam int HALF_BIT_CYC = BIT_CYC / 2;
    localparam int PKT_GAP_US = 10000;
    localparam int PKT_GAP_CYC = (CLK_HZ / 1000) * PKT_GAP_US / 1000;
    localparam int RP_EVERY = 4;
    // ========================================================
    // Register bus, byte addresses
    localparam int AW = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_IMAX = 8'h04;
    localparam logic [7:0] REG_RPGAIN = 8'h08;
    localparam logic [7:0] REG_SWPKT = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_VTARGET = 8'h14;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_SWREQ_BIT = 1;
    localparam logic CTRL_EN_RST = 1'b0;
    localparam logic [15:0] IMAX_RST = 16'h01F4;
    localparam logic [7:0] RPGAIN_RST = 8'h40;
    localparam logic [15:0] SWPKT_RST = 16'h0000;
    localparam int ST_STATE_LSB = 0;
    localparam int ST_SHUT_BIT = 4;
    localparam int ST_ADMODE_BIT = 5;
    localparam int ST_OUTEN_BIT = 6;
    localparam int ST_CONTRACT_BIT = 7;
    localparam int ST_BAND_LSB = 8;
    // ========================================================
    // Packet headers and payload codes
    localparam logic [7:0] HDR_SIG_STRENGTH = 8'h01;
    localparam logic [7:0] HDR_END_POWER = 8'h02;
    localparam logic [7:0] HDR_CTRL_ERROR = 8'h03;
    localparam logic [7:0] HDR_RX_POWER = 8'h04;
    localparam logic [7:0] HDR_CONFIG = 8'h51;
    localparam logic [7:0] HDR_IDENT = 8'h71;
    localparam logic [7:0] EPT_CODE_GENERIC = 8'h01;
    localparam logic [7:0] EPT_CODE_THERMAL = 8'h03;
    localparam logic [10:0] PREAMBLE_BITS = 11'h7FF;
    localparam logic [3:0] FRAME_BITS_M1 = 4'hA;
    // ========================================================
    // Rectifier voltage targets in mV
    localparam logic [15:0] VT_BAND0_MV = 16'h1BA8;
    localparam logic [15:0] VT_BAND1_MV = 16'h1888;
    localparam logic [15:0] VT_BAND2_MV = 16'h159A;
    localparam logic [15:0] VT_BAND3_MV = 16'h13F6;
    localparam logic [15:0] VRECT_BOOST_MV = 16'h1BBC;
    localparam logic [15:0] VRECT_ENABLE_MV = 16'h1B58;
    localparam int CE_SHIFT = 5;
    localparam int FIFO_W = 9;
    localparam int FIFO_D = 16;
    typedef enum logic [3:0] {
        ST_IDLE, ST_SIG, ST_CFG, ST_ID, ST_BOOST, ST_MAIN, ST_EPT, ST_OFF
    } wprx_state_t;
endpackage

// ---- design/wprx_ctrl.sv ----
// Receiver control: packet FIFO and control top with bi-phase load modulator
`timescale 1ns/1ns
// ============================================================
// Overview of operation
// - Talk to transmitter only by switching coil load via mod_out.
// - Send packet bits differential bi-phase at 2 kbps.
// - Generate ident, error, control, end-power and power-usage packets.
// - After ping send signal strength, configuration, then identification first.
// - True shutdown condition at start-up commands transmitter to stop immediately.
// - Power contract and operating point control only after three start-up packets.
// - During start-up request rectifier above 7 V before enabling output.
// - Main loop picks rectifier target from current as percent of max.
// - Repeated control-error packets drive rectifier voltage toward target.
// - New current band updates rectifier target.
// - Every main loop pass checks shutdown and ends power transfer.
// - Report measured received power in packets.
// - Received power derived from power-sense voltage scaled by resistor gain.
// - Light load targets leave 2 V rectifier headroom above output.
// - Targets 7.08, 6.28, 5.53, 5.11 V by bands 10, 20, 40 percent.
// - Both mode selects low selects adapter-control mode.
module wprx_fifo #(
    parameter int W = 9,
    parameter int D = 16
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int PW = $clog2(D);
    logic [W-1:0] mem_q [D];
    logic [PW-1:0] wp_q, rp_q;
    logic [PW:0] cnt_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = cnt_q != (PW+1)'(D);
    assign out_valid = cnt_q != '0;
    assign out_data = mem_q[rp_q];
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else if (clk_en) begin
            if (push) begin
                mem_q[wp_q] <= in_data;
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
    chk_fifo_full: assert property (@(posedge core_clk) disable iff (sys_rst)
        cnt_q == (PW+1)'(D) |-> !in_ready && wp_q == rp_q) else $error("fifo full state inconsistent");
endmodule

module wprx_ctrl
    import wprx_pkg::*;
#(
    parameter int HALF_CYC = HALF_BIT_CYC,
    parameter int GAP_CYC = PKT_GAP_CYC,
    parameter logic [7:0] ID_CODE = 8'h5A,
    parameter logic [7:0] CFG_CODE = 8'h0A
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [AW-1:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [31:0] bus_rdata,
    input wire logic ping_detect,
    input wire logic mode_select_a,
    input wire logic mode_select_b,
    input wire logic adapter_present,
    input wire logic thermistor_control_input,
    input wire logic [15:0] vrect_mv,
    input wire logic [15:0] iout_ma,
    input wire logic [11:0] power_sense_input,
    output logic mod_out,
    output logic out_enable,
    output logic adapter_mode
);
    // ID_CODE and CFG_CODE defaults are arbitrary values
    function automatic logic [1:0] band_of(input logic [15:0] i, input logic [15:0] imax);
        logic [19:0] i10, i5, m2;
        i10 = {4'h0, i} * 20'd10;
        i5 = {4'h0, i} * 20'd5;
        m2 = {4'h0, imax} * 20'd2;
        if (i10 < {4'h0, imax}) band_of = 2'd0;
        else if (i5 < {4'h0, imax}) band_of = 2'd1;
        else if (i5 < m2) band_of = 2'd2;
        else band_of = 2'd3;
    endfunction
    function automatic logic [15:0] target_of(input logic [1:0] b);
        unique case (b)
            2'd0: target_of = VT_BAND0_MV;
            2'd1: target_of = VT_BAND1_MV;
            2'd2: target_of = VT_BAND2_MV;
            2'd3: target_of = VT_BAND3_MV;
        endcase
    endfunction
    function automatic logic [7:0] ce_of(input logic [15:0] tgt, input logic [15:0] vr);
        logic signed [16:0] d;
        d = ($signed({1'b0, tgt}) - $signed({1'b0, vr})) >>> CE_SHIFT;
        if (d > 17'sd127) ce_of = 8'h7F;
        else if (d < -17'sd128) ce_of = 8'h80;
        else ce_of = d[7:0];
    endfunction

    // ========================================================
    // Pin synchronisers
    logic [4:0] sy1_q, sy2_q;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sy1_q <= '0;
            sy2_q <= '0;
        end else if (clk_en) begin
            sy1_q <= {thermistor_control_input, adapter_present, mode_select_b, mode_select_a, ping_detect};
            sy2_q <= sy1_q;
        end
    end
    wire ping_s = sy2_q[0];
    wire ma_s = sy2_q[1];
    wire mb_s = sy2_q[2];
    wire ad_s = sy2_q[3];
    wire th_s = sy2_q[4];
    wire admode_w = !ma_s && !mb_s;
    wire shut_w = (ma_s && mb_s) || (admode_w && ad_s) || th_s;

    // ========================================================
    // Registers
    logic en_q, swpend_q;
    logic [15:0] imax_q, swpkt_q, vtarget_q;
    logic [7:0] rpgain_q;
    logic [31:0] rdata_q;
    wprx_state_t st_q, st_d;
    logic out_en_q, contract_q, admode_q, mod_q;
    logic [1:0] band_q;
    wire wr_ctrl = bus_wr && bus_addr == REG_CTRL;
    wire sw_take;
    wire [31:0] status_w = {22'h0, band_q, contract_q, out_en_q, admode_q, shut_w, st_q};
    wire [31:0] rd_mux = (bus_addr == REG_CTRL) ? {31'h0, en_q} :
                         (bus_addr == REG_IMAX) ? {16'h0, imax_q} :
                         (bus_addr == REG_RPGAIN) ? {24'h0, rpgain_q} :
                         (bus_addr == REG_SWPKT) ? {16'h0, swpkt_q} :
                         (bus_addr == REG_STATUS) ? status_w :
                         (bus_addr == REG_VTARGET) ? {16'h0, vtarget_q} : 32'h0;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            en_q <= CTRL_EN_RST;
            imax_q <= IMAX_RST;
            rpgain_q <= RPGAIN_RST;
            swpkt_q <= SWPKT_RST;
            swpend_q <= 1'b0;
            rdata_q <= 32'h0;
        end else if (clk_en) begin
            if (wr_ctrl) en_q <= bus_wdata[CTRL_EN_BIT];
            if (bus_wr && bus_addr == REG_IMAX) imax_q <= bus_wdata[15:0];
            if (bus_wr && bus_addr == REG_RPGAIN) rpgain_q <= bus_wdata[7:0];
            if (bus_wr && bus_addr == REG_SWPKT) swpkt_q <= bus_wdata[15:0];
            // A new request in the cycle it is taken stays pending
            swpend_q <= (wr_ctrl && bus_wdata[CTRL_SWREQ_BIT]) || (swpend_q && !sw_take);
            rdata_q <= bus_rd ? rd_mux : 32'h0;
        end
    end

    // ========================================================
    // Packet builder: header, payload, checksum into FIFO
    logic bld_busy_q;
    logic [1:0] bld_idx_q;
    logic [7:0] bld_hdr_q, bld_pl_q;
    logic go_w;
    logic [7:0] go_hdr, go_pl;
    wire f_in_ready, f_out_valid, f_pop;
    wire [FIFO_W-1:0] f_out;
    wire [7:0] bld_byte = (bld_idx_q == 2'd0) ? bld_hdr_q :
                          (bld_idx_q == 2'd1) ? bld_pl_q : (bld_hdr_q ^ bld_pl_q);
    wire bld_push = bld_busy_q && f_in_ready;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            bld_busy_q <= 1'b0;
            bld_idx_q <= 2'd0;
            bld_hdr_q <= 8'h00;
            bld_pl_q <= 8'h00;
        end else if (clk_en) begin
            if (go_w) begin
                bld_busy_q <= 1'b1;
                bld_idx_q <= 2'd0;
                bld_hdr_q <= go_hdr;
                bld_pl_q <= go_pl;
            end else if (bld_push) begin
                bld_idx_q <= bld_idx_q + 2'd1;
                if (bld_idx_q == 2'd2) bld_busy_q <= 1'b0;
            end
        end
    end

    wprx_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .in_valid(bld_busy_q),
        .in_ready(f_in_ready),
        .in_data({bld_idx_q == 2'd2, bld_byte}),
        .out_valid(f_out_valid),
        .out_ready(f_pop),
        .out_data(f_out)
    );

    // ========================================================
    // Bi-phase serialiser: preamble, then start, 8 data, parity, stop
    logic [15:0] half_q;
    logic sec_q, busy_q, last_q;
    logic [10:0] sh_q;
    logic [3:0] bits_q;
    wire tick = half_q == 16'(HALF_CYC - 1);
    wire frame_end = busy_q && tick && sec_q && bits_q == 4'h0;
    wire more = !last_q && f_out_valid;
    assign f_pop = frame_end && more;
    wire start_idle = !busy_q && f_out_valid;
    wire bit_start = start_idle || (busy_q && tick && sec_q && (bits_q != 4'h0 || more));
    wire mid_one = busy_q && tick && !sec_q && sh_q[0];
    wire [10:0] frame_w = {1'b1, ~^f_out[7:0], f_out[7:0], 1'b0};
    wire stall = frame_end && !more && !last_q;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            half_q <= 16'h0;
            sec_q <= 1'b0;
            busy_q <= 1'b0;
            last_q <= 1'b0;
            sh_q <= 11'h0;
            bits_q <= 4'h0;
            mod_q <= 1'b0;
        end else if (clk_en) begin
            if (bit_start || mid_one) mod_q <= !mod_q;
            if (start_idle) begin
                busy_q <= 1'b1;
                last_q <= 1'b0;
                sh_q <= PREAMBLE_BITS;
                bits_q <= FRAME_BITS_M1;
                half_q <= 16'h0;
                sec_q <= 1'b0;
            end else if (busy_q && !stall) begin
                half_q <= tick ? 16'h0 : half_q + 16'h1;
                if (tick) sec_q <= !sec_q;
                if (tick && sec_q && bits_q != 4'h0) begin
                    sh_q <= sh_q >> 1;
                    bits_q <= bits_q - 4'h1;
                end else if (frame_end && more) begin
                    sh_q <= frame_w;
                    bits_q <= FRAME_BITS_M1;
                    last_q <= f_out[8];
                end else if (frame_end) begin
                    busy_q <= 1'b0;
                end
            end
        end
    end
    chk_biphase_start: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && bit_start |=> mod_q != $past(mod_q)) else $error("no toggle at bit start");
    chk_bit_period: assert property (@(posedge core_clk) disable iff (sys_rst)
        busy_q |-> half_q <= 16'(HALF_CYC - 1)) else $error("half bit count overran");

    // ========================================================
    // Sequencer
    logic [23:0] gap_q;
    logic [1:0] rpcnt_q;
    wire tx_idle = !busy_q && !f_out_valid && !bld_busy_q;
    wire slot = tx_idle && gap_q >= 24'(GAP_CYC);
    wire [1:0] band_w = band_of(iout_ma, imax_q);
    wire [19:0] rp_prod = {8'h0, power_sense_input} * {12'h0, rpgain_q};
    wire [7:0] rp_byte = rp_prod[19:12];
    wire [7:0] sig_byte = (vrect_mv[15:13] != 3'h0) ? 8'hFF : vrect_mv[12:5];
    wire main_sw = slot && swpend_q;
    wire main_rp = slot && !swpend_q && rpcnt_q == 2'(RP_EVERY - 1);
    assign sw_take = st_q == ST_MAIN && !shut_w && ping_s && main_sw;
    always_comb begin
        st_d = st_q;
        go_w = 1'b0;
        go_hdr = HDR_CTRL_ERROR;
        go_pl = ce_of(vtarget_q, vrect_mv);
        if (st_q != ST_IDLE && !ping_s) begin
            st_d = ST_IDLE;
        end else begin
            unique case (st_q)
                ST_IDLE: if (ping_s && en_q) st_d = ST_SIG;
                ST_SIG, ST_CFG, ST_ID, ST_BOOST, ST_MAIN: begin
                    if (shut_w) begin
                        st_d = ST_EPT;
                    end else if (slot) begin
                        go_w = 1'b1;
                        unique case (st_q)
                            ST_SIG: begin
                                go_hdr = HDR_SIG_STRENGTH;
                                go_pl = sig_byte;
                                st_d = ST_CFG;
                            end
                            ST_CFG: begin
                                go_hdr = HDR_CONFIG;
                                go_pl = CFG_CODE;
                                st_d = ST_ID;
                            end
                            ST_ID: begin
                                go_hdr = HDR_IDENT;
                                go_pl = ID_CODE;
                                st_d = ST_BOOST;
                            end
                            ST_BOOST: begin
                                go_pl = ce_of(VRECT_BOOST_MV, vrect_mv);
                                if (vrect_mv > VRECT_ENABLE_MV) st_d = ST_MAIN;
                            end
                            default: begin
                                if (swpend_q) begin
                                    go_hdr = swpkt_q[7:0];
                                    go_pl = swpkt_q[15:8];
                                end else if (main_rp) begin
                                    go_hdr = HDR_RX_POWER;
                                    go_pl = rp_byte;
                                end
                            end
                        endcase
                    end
                end
                ST_EPT: if (slot) begin
                    go_w = 1'b1;
                    go_hdr = HDR_END_POWER;
                    go_pl = th_s ? EPT_CODE_THERMAL : EPT_CODE_GENERIC;
                    st_d = ST_OFF;
                end
                ST_OFF: ;
            endcase
        end
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_q <= ST_IDLE;
            gap_q <= 24'h0;
            rpcnt_q <= 2'd0;
            vtarget_q <= VT_BAND0_MV;
            band_q <= 2'd0;
            out_en_q <= 1'b0;
            contract_q <= 1'b0;
            admode_q <= 1'b0;
        end else if (clk_en) begin
            st_q <= st_d;
            gap_q <= !tx_idle ? 24'h0 : (slot ? gap_q : gap_q + 24'h1);
            if (go_w && st_q == ST_MAIN && !main_sw) rpcnt_q <= rpcnt_q + 2'd1;
            if (st_q == ST_MAIN) begin
                band_q <= band_w;
                vtarget_q <= target_of(band_w);
            end
            out_en_q <= (st_d == ST_MAIN) && (st_q == ST_MAIN || vrect_mv > VRECT_ENABLE_MV);
            contract_q <= st_d == ST_BOOST || st_d == ST_MAIN;
            admode_q <= admode_w;
        end
    end
    assign mod_out = mod_q;
    assign out_enable = out_en_q;
    assign adapter_mode = admode_q;
    assign bus_rdata = rdata_q;

    chk_out_after_boost: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(out_en_q) |-> $past(vrect_mv) > VRECT_ENABLE_MV) else $error("output on below 7 V");
    chk_startup_order: assert property (@(posedge core_clk) disable iff (sys_rst)
        st_q == ST_BOOST && $past(st_q) != ST_BOOST |-> $past(st_q) == ST_ID) else $error("boost before ident");
    chk_shutdown_ends: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && ping_s && shut_w && st_q inside {ST_SIG, ST_CFG, ST_ID, ST_BOOST, ST_MAIN}
        |=> st_q == ST_EPT && !out_en_q) else $error("shutdown not acted on");
    chk_contract_state: assert property (@(posedge core_clk) disable iff (sys_rst)
        contract_q |-> st_q == ST_BOOST || st_q == ST_MAIN) else $error("contract outside power");
    chk_target_band: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && st_q == ST_MAIN |=> vtarget_q == target_of($past(band_w))) else $error("target not banded");
    chk_adapter_mode: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en |=> admode_q == ($past(!ma_s) && $past(!mb_s))) else $error("adapter mode wrong");
    chk_ce_direction: assert property (@(posedge core_clk) disable iff (sys_rst)
        go_w && go_hdr == HDR_CTRL_ERROR && st_q == ST_MAIN && vrect_mv + 16'h40 < vtarget_q
        |-> !go_pl[7] && go_pl != 8'h00) else $error("control error sign wrong");
endmodule

// ---- verif/wprx_tx_model.sv ----
// Transmitter model: ping source and bi-phase packet decoder
`timescale 1ns/1ns
module wprx_tx_model #(
    parameter int H = 4
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic ping_on,
    input wire logic mod_out,
    output logic ping_detect,
    output logic [7:0] rx_byte,
    output logic rx_stb
);
    logic mod_q = 1'b0;
    logic half_q = 1'b0;
    logic bit_v;
    logic bit_d;
    logic [7:0] sr = 8'h00;
    int cnt = 0;
    int n = 0;
    assign ping_detect = ping_on;
    // ========================================================
    // Decoder: a gap of two halves is a zero, two single halves a one
    always @(posedge core_clk) begin
        bit_v = 1'b0;
        rx_stb <= 1'b0;
        cnt = cnt + 1;
        if (sys_rst) begin
            cnt = 0;
            n = 0;
            half_q = 1'b0;
            mod_q = mod_out;
        end else if (mod_out !== mod_q) begin
            mod_q = mod_out;
            if (cnt > 3 * H) begin
                n = 0;
                half_q = 1'b0;
            end else if (cnt > H + H / 2) begin
                bit_v = 1'b1;
                bit_d = 1'b0;
            end else if (half_q) begin
                bit_v = 1'b1;
                bit_d = 1'b1;
                half_q = 1'b0;
            end else begin
                half_q = 1'b1;
            end
            cnt = 0;
        end else if (cnt == 3 * H && half_q) begin
            bit_v = 1'b1;
            bit_d = 1'b1;
            half_q = 1'b0;
        end
        // Start bit, 8 data bits LSB first, parity, stop
        if (bit_v) begin
            if (n > 0 || !bit_d) n = n + 1;
            if (n >= 2 && n <= 9) sr = {bit_d, sr[7:1]};
            if (n == 9) begin
                rx_byte <= sr;
                rx_stb <= 1'b1;
            end
            if (n == 11) n = 0;
        end
    end
endmodule

// ---- verif/testbench.sv ----
// Testbench: registers, start-up, main loop and shutdown of the receiver control
`timescale 1ns/1ns
module testbench;
    import wprx_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [AW-1:0] bus_addr = '0;
    logic [31:0] bus_wdata = '0;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic clk_en = 1'b1;
    logic [31:0] bus_rdata;
    logic ping_on = 1'b0;
    logic ping_detect;
    logic mode_select_a = 1'b0;
    logic mode_select_b = 1'b0;
    logic adapter_present = 1'b0;
    logic thermistor_control_input = 1'b0;
    logic [15:0] vrect_mv = 16'h1388;
    logic [15:0] iout_ma = 16'h0000;
    logic [11:0] power_sense_input = 12'h000;
    logic mod_out;
    logic out_enable;
    logic adapter_mode;
    logic [7:0] rx_byte;
    logic rx_stb;
    logic [7:0] q[$];
    logic [15:0] cur[4] = '{16'h0031, 16'h0032, 16'h0064, 16'h00C8};
    logic [15:0] vt[4] = '{VT_BAND0_MV, VT_BAND1_MV, VT_BAND2_MV, VT_BAND3_MV};
    int fails = 0;
    int total_checks = 0;
    int k;
    always #20 core_clk = ~core_clk;
    wprx_ctrl #(.HALF_CYC(4), .GAP_CYC(8), .ID_CODE(8'h5A), .CFG_CODE(8'h0A)) wprx_ctrl_i (.core_clk(core_clk),
        .sys_rst(sys_rst), .clk_en(clk_en), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_rdata(bus_rdata), .ping_detect(ping_detect), .mode_select_a(mode_select_a),
        .mode_select_b(mode_select_b), .adapter_present(adapter_present),
        .thermistor_control_input(thermistor_control_input), .vrect_mv(vrect_mv), .iout_ma(iout_ma),
        .power_sense_input(power_sense_input), .mod_out(mod_out), .out_enable(out_enable),
        .adapter_mode(adapter_mode));
    wprx_tx_model #(.H(4)) wprx_tx_model_i (.core_clk(core_clk), .sys_rst(sys_rst), .ping_on(ping_on),
        .mod_out(mod_out), .ping_detect(ping_detect), .rx_byte(rx_byte), .rx_stb(rx_stb));
    always @(posedge core_clk) if (rx_stb) q.push_back(rx_byte);
    // ========================================================
    // Shared tasks
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge core_clk);
        bus_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge core_clk);
        bus_rd <= 1'b0;
        // Read data stand through the cycle after the strobe; take them at its closing edge
        @(posedge core_clk);
        chk(bus_rdata, e);
    endtask
    // Takes packets until the header matches or the tries run out
    task automatic pkt(input logic [7:0] eh, input logic [7:0] ep, input int tries);
        logic [7:0] h;
        logic [7:0] p;
        logic [7:0] c;
        int j;
        int n;
        for (n = 0; n < tries; n++) begin
            for (j = 0; j < 3000 && q.size() < 3; j++) @(posedge core_clk);
            if (q.size() < 3) begin
                fails++;
                complete_run();
            end
            h = q.pop_front();
            p = q.pop_front();
            c = q.pop_front();
            chk(c, h ^ p);
            if (h === eh) break;
        end
        chk(h, eh);
        chk(p, ep);
    endtask
    // ========================================================
    // Main sequence
    initial begin
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (5) @(posedge core_clk);
        chk(adapter_mode, 1'b1);
        rd(REG_IMAX, IMAX_RST);
        // A write while the clock enable is low must be lost
        clk_en <= 1'b0;
        wr(REG_IMAX, 32'h00001234);
        clk_en <= 1'b1;
        rd(REG_IMAX, IMAX_RST);
        rd(REG_RPGAIN, RPGAIN_RST);
        rd(REG_VTARGET, VT_BAND0_MV);
        wr(8'h20, 32'hFFFFFFFF);
        rd(8'h20, 32'h00000000);
        adapter_present <= 1'b1;
        wr(REG_CTRL, 32'h00000001);
        ping_on <= 1'b1;
        pkt(HDR_END_POWER, EPT_CODE_GENERIC, 1);
        ping_on <= 1'b0;
        adapter_present <= 1'b0;
        repeat (20) @(posedge core_clk);
        q.delete();
        ping_on <= 1'b1;
        pkt(HDR_SIG_STRENGTH, 8'h9C, 1);
        pkt(HDR_CONFIG, 8'h0A, 1);
        pkt(HDR_IDENT, 8'h5A, 1);
        pkt(HDR_CTRL_ERROR, 8'h41, 1);
        chk(out_enable, 1'b0);
        vrect_mv <= 16'h1C20;
        for (k = 0; k < 5000 && out_enable !== 1'b1; k++) @(posedge core_clk);
        chk(out_enable, 1'b1);
        rd(REG_STATUS, 32'h000000E5);
        for (k = 0; k < 4; k++) begin
            iout_ma <= cur[k];
            repeat (10) @(posedge core_clk);
            rd(REG_VTARGET, {16'h0000, vt[k]});
        end
        pkt(HDR_CTRL_ERROR, 8'hFC, 1);
        pkt(HDR_CTRL_ERROR, 8'hBE, 4);
        wr(REG_RPGAIN, 32'h00000080);
        power_sense_input <= 12'h800;
        pkt(HDR_RX_POWER, 8'h40, 8);
        wr(REG_SWPKT, 32'h00002231);
        wr(REG_CTRL, 32'h00000003);
        pkt(8'h31, 8'h22, 3);
        thermistor_control_input <= 1'b1;
        pkt(HDR_END_POWER, EPT_CODE_THERMAL, 4);
        chk(out_enable, 1'b0);
        ping_on <= 1'b0;
        mode_select_a <= 1'b1;
        repeat (5) @(posedge core_clk);
        chk(adapter_mode, 1'b0);
        complete_run();
    end
endmodule
